// *** hdl/capture_buffer_defs.svh ***
/*
 * register offsets, field positions, reset values and event bit positions of
 * the capture buffer read-out port.
 * assumes it is included by bare name by the package, the read-out port module and the bench.
 */
`ifndef CAPTURE_BUFFER_DEFS_SVH
`define CAPTURE_BUFFER_DEFS_SVH

`define CB_REG_ADDR_W 8
`define CB_REG_DATA_W 16
`define CB_CTRL_OFS 8'h0f
`define CB_STAT_OFS 8'h10
`define CB_MASK_OFS 8'h11
`define CB_LEVEL_OFS 8'h12
`define CB_CTRL_RST 16'h0000
`define CB_MASK_RST 3'h0
`define CB_DUAL_BIT 12
`define CB_EVT_W 3
`define CB_EVT_UNDERRUN 0
`define CB_EVT_INTERLOCK 1
`define CB_EVT_OVERFLOW 2

`endif

// *** hdl/capture_buffer_pkg.sv ***
/*
 * types shared by the capture buffer read-out port.
 * assumes capture_buffer_defs.svh sits beside it.
 */
`include "capture_buffer_defs.svh"

package capture_buffer_pkg;

	typedef struct packed {
		logic [`CB_REG_ADDR_W-1:0] addr;
		logic [`CB_REG_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} regReq_s;

	typedef logic [`CB_EVT_W-1:0] evtBits_t;

endpackage : capture_buffer_pkg

// *** hdl/capture_mem.sv ***
/*
 * sample store: one write port, two read ports with registered read data.
 * assumes a single clock and a clock enable that freezes it.
 */
module capture_mem #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 12
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic [ADDR_W-1:0] rdAddrA,
	input wire logic [ADDR_W-1:0] rdAddrB,
	output logic [DATA_W-1:0] rdDataA,
	output logic [DATA_W-1:0] rdDataB
);
	logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk)
	begin
		if (ce && wrEn)
		begin
			store[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			rdDataA <= store[rdAddrA];
			rdDataB <= store[rdAddrB];
		end
	end
endmodule : capture_mem

// *** hdl/capture_buffer_readout_port.sv ***
/*
 * read-out side of the sample capture buffer: ports, strobes, empty flag, registers, irq.
 * assumes read clock and enables come from pins; samples and register port from clk logic.
 */
// Local design decision: the strobed register port.
`include "capture_buffer_defs.svh"

module capture_buffer_readout_port #(
	parameter int DATA_W = 8,
	parameter int DEPTH = 4096
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire capture_buffer_pkg::regReq_s regReq,
	output logic [`CB_REG_DATA_W-1:0] regRdata,
	input wire logic readClk,
	input wire logic readEnable,
	input wire logic writeEnable,
	input wire logic [DATA_W-1:0] sampleData,
	input wire logic sampleValid,
	output logic [DATA_W-1:0] primaryDataPort,
	output logic [DATA_W-1:0] secondaryDataPort,
	output logic secondaryOeN,
	output logic primaryDataStrobe,
	output logic secondaryDataStrobe,
	output logic bufferEmptyFlag,
	output logic irq
);
	localparam int ADDR_W = $clog2(DEPTH);
	localparam int CNT_W = ADDR_W + 1;
	// a pair read steps the pointer by two, so at least two address bits are needed
	if (DEPTH < 4 || (1 << ADDR_W) != DEPTH)
	begin : g_depth_check
		$error("DEPTH must be a power of two of at least 4");
	end
	logic [2:0] rclkSh;
	logic [2:0] renSh;
	logic [1:0] wenSh;
	logic [`CB_REG_DATA_W-1:0] ctrl_r;
	capture_buffer_pkg::evtBits_t status_r;
	capture_buffer_pkg::evtBits_t mask_r;
	capture_buffer_pkg::evtBits_t evt;
	logic [ADDR_W-1:0] wrPtr_r;
	logic [ADDR_W-1:0] rdPtr_r;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic [CNT_W-1:0] need;
	logic [DATA_W-1:0] memA;
	logic [DATA_W-1:0] memB;
	logic fetch_r;
	logic fetchDual_r;
	logic dualSel;
	logic rclkRise;
	logic renS;
	logic wenS;
	logic renRise;
	logic readGo;
	logic wrGo;
	// pin synchronisers; index 0 feeds only index 1
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rclkSh <= 3'h0;
			renSh <= 3'h0;
			wenSh <= 2'h0;
		end
		else if (ce)
		begin
			rclkSh <= {rclkSh[1:0], readClk};
			renSh <= {renSh[1:0], readEnable};
			wenSh <= {wenSh[0], writeEnable};
		end
	end

	assign dualSel = ctrl_r[`CB_DUAL_BIT];
	assign rclkRise = rclkSh[1] & ~rclkSh[2];
	assign renS = renSh[1];
	assign renRise = renSh[1] & ~renSh[2];
	assign wenS = wenSh[1];
	assign need = dualSel ? CNT_W'(2) : CNT_W'(1);
	assign readGo = rclkRise && renS && (count_r >= need);
	assign wrGo = wenS && sampleValid && (count_r != CNT_W'(DEPTH));
	assign count_nxt = count_r + CNT_W'(wrGo) - (readGo ? need : CNT_W'(0));

	always_comb
	begin
		evt = '0;
		evt[`CB_EVT_UNDERRUN] = rclkRise && renS && (count_r < need);
		evt[`CB_EVT_INTERLOCK] = renRise && wenSh[1];
		evt[`CB_EVT_OVERFLOW] = wenS && sampleValid && (count_r == CNT_W'(DEPTH));
	end

	// pointers and fill level
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else if (ce)
		begin
			count_r <= count_nxt;
			if (wrGo)
			begin
				wrPtr_r <= wrPtr_r + ADDR_W'(1);
			end
			if (readGo)
			begin
				rdPtr_r <= rdPtr_r + need[ADDR_W-1:0];
			end
		end
	end

	capture_mem #(
		.DATA_W(DATA_W),
		.ADDR_W(ADDR_W)
	) u_mem (
		.clk(clk),
		.ce(ce),
		.wrEn(wrGo),
		.wrAddr(wrPtr_r),
		.wrData(sampleData),
		.rdAddrA(rdPtr_r),
		.rdAddrB(rdPtr_r + ADDR_W'(1)),
		.rdDataA(memA),
		.rdDataB(memB)
	);
	// memory data is valid the cycle after the fetch is issued
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			fetch_r <= 1'b0;
			fetchDual_r <= 1'b0;
		end
		else if (ce)
		begin
			fetch_r <= readGo;
			fetchDual_r <= dualSel;
		end
	end

	// output ports: updated only on a completed fetch, otherwise held
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			primaryDataPort <= '0;
			secondaryDataPort <= '0;
		end
		else if (ce && fetch_r)
		begin
			if (fetchDual_r)
			begin
				secondaryDataPort <= memA;
				primaryDataPort <= memB;
			end
			else
			begin
				primaryDataPort <= memA;
			end
		end
	end

	// strobes trail the sampled read clock by the fetch latency
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			primaryDataStrobe <= 1'b0;
			secondaryDataStrobe <= 1'b0;
			secondaryOeN <= 1'b1;
		end
		else if (ce)
		begin
			primaryDataStrobe <= rclkSh[2];
			secondaryDataStrobe <= rclkSh[2] & dualSel;
			secondaryOeN <= ~dualSel;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bufferEmptyFlag <= 1'b1;
		end
		else if (ce)
		begin
			bufferEmptyFlag <= (count_nxt == '0);
		end
	end

	// registers, sticky status with set over clear, interrupt
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_r <= `CB_CTRL_RST;
			mask_r <= `CB_MASK_RST;
		end
		else if (ce && regReq.wr)
		begin
			if (regReq.addr == `CB_CTRL_OFS)
			begin
				ctrl_r <= regReq.wdata;
			end
			if (regReq.addr == `CB_MASK_OFS)
			begin
				mask_r <= regReq.wdata[`CB_EVT_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			status_r <= '0;
		end
		else if (ce)
		begin
			if (regReq.wr && regReq.addr == `CB_STAT_OFS)
			begin
				status_r <= (status_r & ~regReq.wdata[`CB_EVT_W-1:0]) | evt;
			end
			else
			begin
				status_r <= status_r | evt;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			irq <= 1'b0;
			regRdata <= '0;
		end
		else if (ce)
		begin
			irq <= |(status_r & mask_r);
			regRdata <= '0;
			if (regReq.rd)
			begin
				unique case (regReq.addr)
					`CB_CTRL_OFS: regRdata <= ctrl_r;
					`CB_STAT_OFS: regRdata <= `CB_REG_DATA_W'(status_r);
					`CB_MASK_OFS: regRdata <= `CB_REG_DATA_W'(mask_r);
					`CB_LEVEL_OFS: regRdata <= `CB_REG_DATA_W'(count_r);
					default: regRdata <= '0;
				endcase
			end
		end
	end

	a_hold_data: assert property (@(posedge clk) disable iff (rst)
		!fetch_r |=> $stable(primaryDataPort))
		else $error("primary port changed without a read");
	a_single_port: assert property (@(posedge clk) disable iff (rst)
		ce && fetch_r && !fetchDual_r |=> primaryDataPort == $past(memA))
		else $error("single-port read data wrong");
	a_dual_order: assert property (@(posedge clk) disable iff (rst)
		ce && fetch_r && fetchDual_r |=> secondaryDataPort == $past(memA)
		&& primaryDataPort == $past(memB))
		else $error("dual-port sample order wrong");
	a_sec_float: assert property (@(posedge clk) disable iff (rst)
		ce && !dualSel |=> secondaryOeN && !secondaryDataStrobe)
		else $error("secondary port driven in single-port mode");
	a_strobe_align: assert property (@(posedge clk) disable iff (rst)
		ce && fetch_r ##1 ce |-> $rose(primaryDataStrobe))
		else $error("strobe not aligned with data update");
	a_byte_count: assert property (@(posedge clk) disable iff (rst)
		ce && readGo && !dualSel && !wrGo |=> count_r == $past(count_r) - CNT_W'(1))
		else $error("single read did not take one byte");
	a_dual_split: assert property (@(posedge clk) disable iff (rst)
		ce && readGo && dualSel |=> rdPtr_r == $past(rdPtr_r) + ADDR_W'(2) && fetchDual_r)
		else $error("dual read did not take a pair");
	a_empty_write: assert property (@(posedge clk) disable iff (rst)
		ce && wrGo |=> !bufferEmptyFlag)
		else $error("empty flag high after a write");
	a_interlock_flag: assert property (@(posedge clk) disable iff (rst)
		ce && renRise && wenS |=> status_r[`CB_EVT_INTERLOCK])
		else $error("interlock violation not recorded");
endmodule : capture_buffer_readout_port

// *** tb/capture_reader.sv ***
/*
 * far-side reader model: free-running read clock and read enable.
 * assumes the bench raises go only while it wants bytes read out.
 */
module capture_reader (
	input wire logic go,
	input wire logic writeEnable,
	output logic readClk,
	output logic readEnable
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		readClk = 1'b0;
		readEnable = 1'b0;
	end
	always #400 readClk = ~readClk;
	// enable moves on the falling read clock, never raised while writes run
	always @(negedge readClk)
		readEnable <= go && (readEnable || !writeEnable);
endmodule : capture_reader

// *** tb/test_capture_buffer_readout_port.sv ***
/*
 * self-checking bench for the capture buffer read-out port.
 * assumes the design files under hdl/ and the reader model beside it.
 */
`include "capture_buffer_defs.svh"
module test_capture_buffer_readout_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, ce = 1, go = 0, writeEnable = 0, sampleValid = 0, prevStrobe = 0;
	logic [7:0] sampleData = 8'h00, val, lastP = 8'h00, primaryDataPort, secondaryDataPort;
	logic [15:0] regRdata, d;
	logic readClk, readEnable, secondaryOeN, primaryDataStrobe, secondaryDataStrobe;
	logic bufferEmptyFlag, irq;
	capture_buffer_pkg::regReq_s regReq = '0;
	logic [7:0] seen[$], expq[$];
	int errCount = 0, nTests = 0, cycles = 0, n;
	always #50 clk = ~clk;
	capture_buffer_readout_port #(.DEPTH(16)) capture_buffer_readout_port_i (.clk(clk),
		.rst(rst), .ce(ce), .regReq(regReq), .regRdata(regRdata), .readClk(readClk),
		.readEnable(readEnable), .writeEnable(writeEnable), .sampleData(sampleData),
		.sampleValid(sampleValid), .primaryDataPort(primaryDataPort),
		.secondaryDataPort(secondaryDataPort), .secondaryOeN(secondaryOeN),
		.primaryDataStrobe(primaryDataStrobe), .secondaryDataStrobe(secondaryDataStrobe),
		.bufferEmptyFlag(bufferEmptyFlag), .irq(irq));
	capture_reader capture_reader_i (.go(go), .writeEnable(writeEnable), .readClk(readClk),
		.readEnable(readEnable));
	task results;
		$display("tests %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	task check(input string name, input logic [15:0] seenV, input logic [15:0] expV);
		nTests++;
		if (seenV !== expV)
		begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", name, expV, seenV);
		end
	endtask : check
	// expected status word with one event bit set
	function automatic logic [15:0] evtWord(input int pos);
		return 16'h0001 << pos;
	endfunction : evtWord
	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk) regReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk) regReq <= '0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk) regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk) regReq <= '0;
		#1 v = regRdata;
	endtask : rd
	task fill(input int k);
		@(posedge clk) writeEnable <= 1'b1;
		repeat (4) @(posedge clk);
		repeat (k)
		begin
			expq.push_back(val);
			sampleData <= val;
			sampleValid <= 1'b1;
			val++;
			@(posedge clk);
		end
		sampleValid <= 1'b0;
		writeEnable <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : fill
	task drain(input int k);
		@(posedge clk) go <= 1'b1;
		repeat (k * 8) @(posedge clk);
		go <= 1'b0;
		repeat (24) @(posedge clk);
		check("count", 16'(seen.size()), 16'(expq.size()));
		foreach (expq[i]) check("data", seen[i], expq[i]);
		check("hold", primaryDataPort, expq[$]);
		seen.delete();
		expq.delete();
	endtask : drain
	always @(posedge clk)
	begin
		prevStrobe <= primaryDataStrobe;
		if (primaryDataStrobe && !prevStrobe && primaryDataPort !== lastP)
		begin
			if (secondaryOeN === 1'b0)
			begin
				seen.push_back(secondaryDataPort);
				check("strobe2", secondaryDataStrobe, 1);
			end
			seen.push_back(primaryDataPort);
			lastP = primaryDataPort;
		end
		cycles++;
		if (cycles == 6000)
		begin
			errCount++;
			results;
		end
	end
	initial
	begin
		void'($urandom(88833));
		val = 8'($urandom_range(150, 1));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`CB_CTRL_OFS, d);
		check("ctrl reset", d, 16'h0000);
		wr(`CB_CTRL_OFS, 16'h1000);
		rd(`CB_CTRL_OFS, d);
		check("ctrl", d, 16'h1000);
		rd(8'h20, d);
		check("unmapped", d, 16'h0000);
		wr(`CB_CTRL_OFS, 16'h0000);
		check("empty", bufferEmptyFlag, 1);
		n = 2 * $urandom_range(4, 1);
		fill(n);
		check("empty", bufferEmptyFlag, 0);
		rd(`CB_LEVEL_OFS, d);
		check("level", d, 16'(n));
		drain(n + 3);
		check("oe2", secondaryOeN, 1);
		check("empty", bufferEmptyFlag, 1);
		$display("single-port test done");
		rd(`CB_STAT_OFS, d);
		check("underrun", d, evtWord(`CB_EVT_UNDERRUN));
		check("irq", irq, 0);
		wr(`CB_MASK_OFS, 16'h0001);
		repeat (2) @(posedge clk);
		check("irq", irq, 1);
		wr(`CB_STAT_OFS, 16'h0007);
		repeat (2) @(posedge clk);
		check("irq", irq, 0);
		rd(`CB_STAT_OFS, d);
		check("status", d, 16'h0000);
		$display("interrupt test done");
		wr(`CB_CTRL_OFS, 16'h1000);
		fill(16);
		drain(11);
		check("oe2", secondaryOeN, 0);
		$display("dual-port test done");
		// one sample more than the store holds: the last is dropped and flagged
		fill(17);
		rd(`CB_STAT_OFS, d);
		check("overflow", d & evtWord(`CB_EVT_OVERFLOW), evtWord(`CB_EVT_OVERFLOW));
		rd(`CB_LEVEL_OFS, d);
		check("full level", d, 16'h0010);
		$display("overflow test done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		check("empty", bufferEmptyFlag, 1);
		check("port reset", primaryDataPort, 16'h0000);
		check("oe2 reset", secondaryOeN, 1);
		rst <= 1'b0;
		rd(`CB_LEVEL_OFS, d);
		check("level", d, 16'h0000);
		rd(`CB_CTRL_OFS, d);
		check("ctrl", d, 16'h0000);
		// with the clock enable low a register write must be ignored
		@(posedge clk) ce <= 1'b0;
		wr(`CB_CTRL_OFS, 16'h1000);
		ce <= 1'b1;
		rd(`CB_CTRL_OFS, d);
		check("freeze", d, 16'h0000);
		$display("reset test done");
		results;
	end
endmodule : test_capture_buffer_readout_port
